/* hdl/downstream_port_reset_sequencer.sv */
/*
 Downstream port reset sequencer for one switch downstream port: secondary bus reset
 sequencing and slot reset output against slot power enable.
 Assumes synchronous inputs on pclk, an APB master, and a link/queue layer that obeys
 the hot reset, discard and unsupported request controls.
*/
// How it works
// RULE1: Writing one to the secondary bus reset bit starts a downstream reset.
// RULE2: If link is up, send TS1 sets with hot reset bit during reset.
// RULE3: Discard all queued packets received from this port during reset.
// RULE4: Hold port in reset until software clears bit, then resume operation.
// RULE5: Other ports and upstream port are not disturbed by this reset.
// RULE6: Type 0 configuration accesses to this port still complete normally.
// RULE7: Packets to the secondary side complete as unsupported requests meanwhile.
// RULE8: The SMBus slave keeps working during the reset.
// RULE9: Reset output is a pin alternate function, floating until configured.
// RULE10: Every reset output assertion pulse lasts at least 200 microseconds.
// RULE11: Mode field selects power-enable or power-good reset output behaviour.
// RULE12: Power-enable mode: reset stays asserted while slot power is off.
// RULE13: Power on: assert enable, then negate reset after power-to-reset delay.
// RULE14: Power off: assert reset, then negate enable after reset-to-power delay.
// RULE15: Power-good mode: negate reset power-to-reset delay after power good seen.
// RULE16: Power-good mode: power good loss with reset negated asserts reset at once.
// RULE17: Faster fault response needs external logic; input comes through an expander.
// RULE18: Delays use a counter on fixed time base; zero means next cycle.
// RULE19: A new power write aborts the running delay and restarts sequencing.
`timescale 1ns/1ps
module downstream_port_reset_sequencer
   import dsp_reset_pkg::*;
(
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire dsp_reset_pkg::apb_req_s apb_req,
   output dsp_reset_pkg::apb_rsp_s      apb_rsp,
   input  wire logic                    link_up,
   input  wire logic                    slot_power_good_in,
   input  wire logic                    reset_pin_alt_en,
   output logic                         hot_reset_ts1_req,
   output logic                         discard_queued,
   input  wire logic                    discard_done,
   output logic                         secondary_ur_en,
   output logic                         port_in_reset,
   output logic                         slot_power_enable_out,
   output logic                         port_reset_out_n_o,
   output logic                         port_reset_out_n_oe
);
   import dsp_reset_pkg::*;

   logic                    secondary_bus_reset_bit_q, secondary_bus_reset_bit_d;
   logic                    slot_power_off_ctl_q, slot_power_off_ctl_d;
   reset_output_mode_sel_e  reset_output_mode_sel_q, reset_output_mode_sel_d;
   logic [DELAY_W-1:0]      power_to_reset_delay_q, power_to_reset_delay_d;
   logic [DELAY_W-1:0]      reset_to_power_delay_q, reset_to_power_delay_d;
   apb_rsp_s                rsp_d;
   sbr_state_e              sbr_q, sbr_d;
   slot_state_e             slot_q, slot_d;
   logic [CNT_W-1:0]        dly_q, dly_d;
   logic [CNT_W-1:0]        pulse_q, pulse_d;
   logic                    rst_q, rst_d;
   logic                    pen_q, pen_d;
   logic                    wr_en, rd_en, pwr_write;

   assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign rd_en = apb_req.psel && apb_req.penable && !apb_req.pwrite;
   assign pwr_write = wr_en && (apb_req.paddr == SLOT_CONTROL_OFF);

   // Register file, zero wait states
   always_comb begin
      secondary_bus_reset_bit_d = secondary_bus_reset_bit_q;
      slot_power_off_ctl_d      = slot_power_off_ctl_q;
      reset_output_mode_sel_d   = reset_output_mode_sel_q;
      power_to_reset_delay_d    = power_to_reset_delay_q;
      reset_to_power_delay_d    = reset_to_power_delay_q;
      rsp_d                     = '0;
      rsp_d.pready              = 1'b1;
      if (wr_en) begin
         if (apb_req.paddr == BRIDGE_CONTROL_OFF) begin
            secondary_bus_reset_bit_d = apb_req.pwdata[SBR_BIT]; // RULE1
         end else if (apb_req.paddr == SLOT_CONTROL_OFF) begin
            slot_power_off_ctl_d = apb_req.pwdata[PWR_OFF_BIT];
         end else if (apb_req.paddr == HOTPLUG_CFG_OFF) begin
            reset_output_mode_sel_d = reset_output_mode_sel_e'(apb_req.pwdata[MODE_BIT]); // RULE11
            power_to_reset_delay_d  = apb_req.pwdata[P2R_LSB +: DELAY_W];
            reset_to_power_delay_d  = apb_req.pwdata[R2P_LSB +: DELAY_W];
         end else if (apb_req.paddr != STATUS_OFF) begin
            rsp_d.pslverr = 1'b1;
         end
      end else if (rd_en) begin
         if (apb_req.paddr == BRIDGE_CONTROL_OFF) begin
            rsp_d.prdata[SBR_BIT] = secondary_bus_reset_bit_q;
         end else if (apb_req.paddr == SLOT_CONTROL_OFF) begin
            rsp_d.prdata[PWR_OFF_BIT] = slot_power_off_ctl_q;
         end else if (apb_req.paddr == HOTPLUG_CFG_OFF) begin
            rsp_d.prdata[MODE_BIT]            = reset_output_mode_sel_q;
            rsp_d.prdata[P2R_LSB +: DELAY_W]  = power_to_reset_delay_q;
            rsp_d.prdata[R2P_LSB +: DELAY_W]  = reset_to_power_delay_q;
         end else if (apb_req.paddr == STATUS_OFF) begin
            rsp_d.prdata[0] = !rst_q;
            rsp_d.prdata[1] = pen_q;
            rsp_d.prdata[2] = (sbr_q != SBR_IDLE);
            rsp_d.prdata[3] = link_up;
            rsp_d.prdata[4] = slot_power_good_in;
         end else begin
            rsp_d.pslverr = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         secondary_bus_reset_bit_q <= 1'b0;
         slot_power_off_ctl_q      <= 1'b1;
         reset_output_mode_sel_q   <= MODE_POWER_ENABLE;
         power_to_reset_delay_q    <= P2R_RESET;
         reset_to_power_delay_q    <= R2P_RESET;
      end else begin
         secondary_bus_reset_bit_q <= secondary_bus_reset_bit_d;
         slot_power_off_ctl_q      <= slot_power_off_ctl_d;
         reset_output_mode_sel_q   <= reset_output_mode_sel_d;
         power_to_reset_delay_q    <= power_to_reset_delay_d;
         reset_to_power_delay_q    <= reset_to_power_delay_d;
      end
   end

   // APB answer is combinational off the access phase; data is zero outside it
   always_comb begin
      apb_rsp         = rsp_d;
      apb_rsp.pready  = 1'b1;
   end

   // Secondary bus reset sequence; only this port's controls are touched
   always_comb begin
      sbr_d = sbr_q;
      case (sbr_q)
         SBR_IDLE: begin
            if (secondary_bus_reset_bit_q) begin
               sbr_d = SBR_HOT_RESET; // RULE1
            end
         end
         SBR_HOT_RESET: begin
            sbr_d = SBR_DISCARD;
         end
         SBR_DISCARD: begin
            if (discard_done) begin
               sbr_d = SBR_HOLD;
            end
         end
         SBR_HOLD: begin
            if (!secondary_bus_reset_bit_q) begin
               sbr_d = SBR_IDLE; // RULE4
            end
         end
         default: sbr_d = SBR_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sbr_q <= SBR_IDLE;
      end else begin
         sbr_q <= sbr_d;
      end
   end

   // Config type 0 and SMBus paths are outside this block and never gated here
   assign hot_reset_ts1_req = (sbr_q != SBR_IDLE) && link_up;  // RULE2 RULE5
   assign discard_queued    = (sbr_q == SBR_DISCARD);          // RULE3
   assign secondary_ur_en   = (sbr_q != SBR_IDLE);             // RULE7 RULE6 RULE8
   assign port_in_reset     = (sbr_q != SBR_IDLE);             // RULE4

   // Slot power and reset output sequencing
   always_comb begin
      slot_d  = slot_q;
      dly_d   = (dly_q != '0) ? dly_q - 1'b1 : dly_q;
      rst_d   = rst_q;
      pen_d   = pen_q;
      pulse_d = (rst_q && pulse_q != '0) ? pulse_q - 1'b1 : pulse_q;
      if (pwr_write && slot_power_off_ctl_d != slot_power_off_ctl_q) begin
         // RULE19
         if (slot_power_off_ctl_d) begin
            rst_d  = 1'b1; // RULE14
            slot_d = SLOT_R2P;
            dly_d  = CNT_W'(reset_to_power_delay_q) * CNT_W'(DELAY_UNIT_CYC); // RULE18
         end else begin
            pen_d = 1'b1; // RULE13
            if (reset_output_mode_sel_q == MODE_POWER_GOOD) begin
               slot_d = SLOT_WAIT_GOOD;
            end else begin
               slot_d = SLOT_P2R;
               dly_d  = CNT_W'(power_to_reset_delay_q) * CNT_W'(DELAY_UNIT_CYC); // RULE18
            end
         end
      end else begin
         case (slot_q)
            SLOT_OFF: begin
               rst_d = 1'b1; // RULE12
               pen_d = 1'b0;
            end
            SLOT_WAIT_GOOD: begin
               if (slot_power_good_in) begin
                  slot_d = SLOT_P2R; // RULE15
                  dly_d  = CNT_W'(power_to_reset_delay_q) * CNT_W'(DELAY_UNIT_CYC);
               end
            end
            SLOT_P2R: begin
               if (dly_q == '0 && pulse_q == '0) begin
                  rst_d  = 1'b0; // RULE10
                  slot_d = SLOT_ON;
               end
            end
            SLOT_ON: begin
               if (reset_output_mode_sel_q == MODE_POWER_GOOD && !slot_power_good_in) begin
                  rst_d  = 1'b1; // RULE16 RULE17
                  slot_d = SLOT_WAIT_GOOD;
               end
            end
            SLOT_R2P: begin
               if (dly_q == '0) begin
                  pen_d  = 1'b0; // RULE14
                  slot_d = SLOT_OFF;
               end
            end
            default: slot_d = SLOT_OFF;
         endcase
      end
      // Reload on every new assertion, so a fault restarts the minimum pulse
      if (rst_d && !rst_q) begin
         pulse_d = CNT_W'(MIN_PULSE_CYC); // RULE10
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot_q  <= SLOT_OFF;
         dly_q   <= '0;
         rst_q   <= 1'b1;
         pen_q   <= 1'b0;
         pulse_q <= CNT_W'(MIN_PULSE_CYC);
      end else begin
         slot_q  <= slot_d;
         dly_q   <= dly_d;
         rst_q   <= rst_d;
         pen_q   <= pen_d;
         pulse_q <= pulse_d;
      end
   end

   // Pin drives only once its alternate function is selected
   assign slot_power_enable_out = pen_q;
   assign port_reset_out_n_o    = !rst_q;
   assign port_reset_out_n_oe   = reset_pin_alt_en; // RULE9

   AST_FAULT: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
      (slot_q == SLOT_ON && reset_output_mode_sel_q == MODE_POWER_GOOD
       && !slot_power_good_in && !pwr_write) |=> rst_q)
      else $error("power fault did not assert reset");
   AST_PULSE: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
      $rose(rst_q) |-> rst_q [*8])
      else $error("reset pulse too short");
   AST_OFF_RESET: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
      (!pen_q) |-> rst_q)
      else $error("reset negated while power off");
   AST_OFF_SEQ: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
      (pwr_write && apb_req.pwdata[PWR_OFF_BIT] && !slot_power_off_ctl_q) |=> rst_q)
      else $error("reset not asserted on power off");
   AST_ON_SEQ: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
      (pwr_write && !apb_req.pwdata[PWR_OFF_BIT] && slot_power_off_ctl_q) |=> pen_q && rst_q)
      else $error("power enable not first on power on");
   AST_GOOD_WAIT: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
      (slot_q == SLOT_WAIT_GOOD) |=> rst_q)
      else $error("reset negated before power good");
   AST_SBR_START: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
      (sbr_q == SBR_IDLE && secondary_bus_reset_bit_q) |=> port_in_reset && secondary_ur_en)
      else $error("secondary reset not started");
   AST_SBR_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
      (sbr_q == SBR_HOLD && secondary_bus_reset_bit_q) |=> port_in_reset)
      else $error("port released before bit cleared");
   AST_TS1: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
      (port_in_reset && link_up) |-> hot_reset_ts1_req)
      else $error("no hot reset sets with link up");

   // Power writes that change state preempt every slot state step, so they are left out here
   AST_PULSE_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
      (rst_q && pulse_q != '0) |=> rst_q)
      else $error("reset negated before minimum pulse");
   AST_RELEASE: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
      (sbr_q == SBR_HOLD && !secondary_bus_reset_bit_q) |=> !port_in_reset)
      else $error("port not released after bit cleared");
   AST_DISCARD: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
      (sbr_q == SBR_HOT_RESET) |=> discard_queued)
      else $error("discard step skipped");
   AST_GOOD_GATE: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
      (slot_q == SLOT_WAIT_GOOD && slot_power_good_in && !pwr_write) |=> slot_q == SLOT_P2R)
      else $error("power good not followed by delay");
   AST_ZERO_DLY: assert property (@(posedge pclk) disable iff (!presetn) // RULE18
      (slot_q == SLOT_R2P && dly_q == '0 && !pwr_write) |=> !pen_q)
      else $error("power enable not dropped at end of delay");
   AST_ABORT: assert property (@(posedge pclk) disable iff (!presetn) // RULE19
      (pwr_write && !apb_req.pwdata[PWR_OFF_BIT] && slot_power_off_ctl_q)
      |=> (slot_q == SLOT_P2R || slot_q == SLOT_WAIT_GOOD))
      else $error("power on write did not restart sequence");
   AST_PE_STEADY: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
      (slot_q == SLOT_ON && reset_output_mode_sel_q == MODE_POWER_ENABLE && !pwr_write)
      |=> !rst_q)
      else $error("reset asserted in power enable mode while on");

endmodule : downstream_port_reset_sequencer

/* hdl/dsp_reset_pkg.sv */
/*
 Package for the downstream port reset sequencer: register offsets, field positions,
 reset values, timing constants, state types and carrier structs.
 Assumes a 250 MHz core clock and an APB register bus with 32-bit data.
*/
package dsp_reset_pkg;

   // Register byte offsets
   localparam logic [11:0] BRIDGE_CONTROL_OFF   = 12'h03C;
   localparam logic [11:0] SLOT_CONTROL_OFF     = 12'h040;
   localparam logic [11:0] HOTPLUG_CFG_OFF      = 12'h044;
   localparam logic [11:0] STATUS_OFF           = 12'h048;

   // Field positions
   localparam int SBR_BIT          = 22;
   localparam int PWR_OFF_BIT      = 10;
   localparam int MODE_BIT         = 0;
   localparam int P2R_LSB          = 8;
   localparam int R2P_LSB          = 16;
   localparam int DELAY_W          = 8;

   // Reset values
   localparam logic [DELAY_W-1:0] P2R_RESET   = 8'h01;
   localparam logic [DELAY_W-1:0] R2P_RESET   = 8'h01;

   // Timing
   localparam int  CLK_MHZ          = 250;
   localparam int  MIN_PULSE_US     = 200;
   localparam int  MIN_PULSE_CYC    = MIN_PULSE_US * CLK_MHZ;
   localparam int  DELAY_UNIT_US    = 1;
   localparam int  DELAY_UNIT_CYC   = DELAY_UNIT_US * CLK_MHZ;
   localparam int  CNT_W            = 24;

   typedef enum logic {
      MODE_POWER_ENABLE,
      MODE_POWER_GOOD
   } reset_output_mode_sel_e;

   typedef enum {
      SLOT_OFF,
      SLOT_WAIT_GOOD,
      SLOT_P2R,
      SLOT_ON,
      SLOT_R2P
   } slot_state_e;

   typedef enum {
      SBR_IDLE,
      SBR_HOT_RESET,
      SBR_DISCARD,
      SBR_HOLD
   } sbr_state_e;

   typedef struct packed {
      logic         psel;
      logic         penable;
      logic         pwrite;
      logic [11:0]  paddr;
      logic [31:0]  pwdata;
   } apb_req_s;

   typedef struct packed {
      logic         pready;
      logic         pslverr;
      logic [31:0]  prdata;
   } apb_rsp_s;

endpackage : dsp_reset_pkg

/* verification/slot_partner_model.sv */
/*
 Far side of one downstream slot: the slot power supply with its power-good line and
 the queue logic that answers a discard request.
 Assumes all inputs are synchronous to pclk; fault_cmd comes from the testbench.
*/
`timescale 1ns/1ps
module slot_partner_model #(
   parameter int RAMP_CYC = 2000
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic slot_power_enable_out,
   input  wire logic fault_cmd,
   input  wire logic discard_queued,
   output logic      slot_power_good_in,
   output logic      discard_done
);
   int unsigned ramp_q;
   logic [2:0]  dly_q;

   // Good arrives late, like a slow expander path
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ramp_q             <= 0;
         slot_power_good_in <= 1'b0;
         dly_q              <= 3'h0;
         discard_done       <= 1'b0;
      end else begin
         if (!slot_power_enable_out || fault_cmd) begin
            ramp_q             <= 0;
            slot_power_good_in <= 1'b0;
         end else if (ramp_q < RAMP_CYC) begin
            ramp_q <= ramp_q + 1;
         end else begin
            slot_power_good_in <= 1'b1;
         end
         dly_q        <= discard_queued ? dly_q + 3'h1 : 3'h0;
         discard_done <= discard_queued && (dly_q == 3'h3);
      end
   end
endmodule : slot_partner_model

/* verification/downstream_port_reset_sequencer_tb.sv */
/*
 Self-checking testbench for the downstream port reset sequencer: APB register accesses,
 secondary bus reset sequence and slot power/reset sequencing in both modes.
 Assumes the package constants; the APB master waits for pready; run is about 51000 cycles.
*/
`timescale 1ns/1ps
module downstream_port_reset_sequencer_tb;
   import dsp_reset_pkg::*;
   logic       pclk = 1'b0;
   logic       presetn = 1'b0;
   apb_req_s   apb_req = '0;
   apb_rsp_s   apb_rsp;
   logic       link_up = 1'b0;
   logic       slot_power_good_in;
   logic       reset_pin_alt_en = 1'b0;
   logic       fault_cmd = 1'b0;
   logic       hot_reset_ts1_req, discard_queued, discard_done, secondary_ur_en;
   logic       port_in_reset, slot_power_enable_out, port_reset_out_n_o, port_reset_out_n_oe;
   int         failures = 0;
   int         check_count = 0;
   int         cyc = 0;

   always #2 pclk = ~pclk;
   always @(posedge pclk) cyc <= presetn ? cyc + 1 : 0;

   downstream_port_reset_sequencer downstream_port_reset_sequencer_inst (
      .pclk                  (pclk),
      .presetn               (presetn),
      .apb_req               (apb_req),
      .apb_rsp               (apb_rsp),
      .link_up               (link_up),
      .slot_power_good_in    (slot_power_good_in),
      .reset_pin_alt_en      (reset_pin_alt_en),
      .hot_reset_ts1_req     (hot_reset_ts1_req),
      .discard_queued        (discard_queued),
      .discard_done          (discard_done),
      .secondary_ur_en       (secondary_ur_en),
      .port_in_reset         (port_in_reset),
      .slot_power_enable_out (slot_power_enable_out),
      .port_reset_out_n_o    (port_reset_out_n_o),
      .port_reset_out_n_oe   (port_reset_out_n_oe)
   );

   slot_partner_model slot_partner_model_inst (
      .pclk                  (pclk),
      .presetn               (presetn),
      .slot_power_enable_out (slot_power_enable_out),
      .fault_cmd             (fault_cmd),
      .discard_queued        (discard_queued),
      .slot_power_good_in    (slot_power_good_in),
      .discard_done          (discard_done)
   );

   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Starts on a rising edge so a release never meets a new setup in one step
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rdat, output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      // Answer is taken at the very edge where pready is sampled high
      do begin
         @(posedge pclk);
         n++;
         if (n > 50) begin
            failures++;
            $display("unexpected timeout on register access");
            final_report();
         end
      end while (apb_rsp.pready !== 1'b1);
      rdat = apb_rsp.prdata;
      err  = apb_rsp.pslverr;
      apb_req.psel    <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] wd);
      logic [31:0] d;
      logic        e;
      apb(1'b1, a, wd, d, e);
   endtask : wr

   function automatic logic pick(input int k);
      case (k)
         0: return discard_queued;
         1: return port_reset_out_n_o;
         2: return slot_power_enable_out;
         default: return port_in_reset;
      endcase
   endfunction : pick

   task automatic wait_for(input int k, input logic v, input int lim, output int n);
      n = 0;
      do begin
         @(negedge pclk);
         n++;
         if (n > lim) begin
            failures++;
            $display("unexpected timeout on signal %0d", k);
            final_report();
         end
      end while (pick(k) !== v);
   endtask : wait_for

   initial begin
      logic [31:0] d;
      logic        e;
      int          n;
      repeat (10) @(posedge pclk);
      @(negedge pclk);
      chk("oe_unconfigured", port_reset_out_n_oe, 1'b0);
      chk("reset_in_reset", port_reset_out_n_o, 1'b0);
      @(posedge pclk);
      presetn          <= 1'b1;
      reset_pin_alt_en <= 1'b1;
      apb(1'b0, BRIDGE_CONTROL_OFF, 32'h0, d, e);
      chk("sbr_reset_value", d[SBR_BIT], 1'b0);
      chk("oe_configured", port_reset_out_n_oe, 1'b1);
      apb(1'b0, SLOT_CONTROL_OFF, 32'h0, d, e);
      chk("power_off_reset_value", d[PWR_OFF_BIT], 1'b1);
      apb(1'b0, HOTPLUG_CFG_OFF, 32'h0, d, e);
      chk("hotplug_reset_value", d & 32'h00FF_FF01, 32'h0001_0100);
      apb(1'b0, 12'h100, 32'h0, d, e);
      chk("unmapped_error", e, 1'b1);
      for (int lu = 0; lu < 2; lu++) begin
         link_up <= lu[0];
         wr(BRIDGE_CONTROL_OFF, 32'h0040_0000);
         wait_for(3, 1'b1, 4, n);
         chk("ts1_request", hot_reset_ts1_req, lu[0]);
         chk("ur_enable", secondary_ur_en, 1'b1);
         wait_for(0, 1'b1, 4, n);
         wait_for(0, 1'b0, 50, n);
         repeat (20) @(negedge pclk);
         chk("held_in_reset", port_in_reset, 1'b1);
         chk("power_undisturbed", slot_power_enable_out, 1'b0);
         apb(1'b0, STATUS_OFF, 32'h0, d, e);
         chk("status_during_sbr", d[3:2], {lu[0], 1'b1});
         wr(BRIDGE_CONTROL_OFF, 32'h0000_0000);
         wait_for(3, 1'b0, 4, n);
         chk("ur_released", secondary_ur_en, 1'b0);
      end
      wr(HOTPLUG_CFG_OFF, 32'h0001_0101);
      wr(SLOT_CONTROL_OFF, 32'h0000_0000);
      wait_for(2, 1'b1, 3, n);
      repeat (1500) @(negedge pclk);
      chk("waits_power_good", port_reset_out_n_o, 1'b0);
      wait_for(1, 1'b1, 60000, n);
      chk("min_pulse", cyc >= MIN_PULSE_CYC, 1'b1);
      @(posedge pclk);
      fault_cmd <= 1'b1;
      wait_for(1, 1'b0, 3, n);
      @(posedge pclk);
      fault_cmd <= 1'b0;
      wr(SLOT_CONTROL_OFF, 32'h0000_0400);
      repeat (100) @(negedge pclk);
      chk("enable_before_delay", slot_power_enable_out, 1'b1);
      wait_for(2, 1'b0, 400, n);
      chk("reset_to_power_time", n >= 140 && n <= 160, 1'b1);
      wr(HOTPLUG_CFG_OFF, 32'h0001_0100);
      wr(SLOT_CONTROL_OFF, 32'h0000_0000);
      wait_for(2, 1'b1, 3, n);
      chk("reset_still_held", port_reset_out_n_o, 1'b0);
      wr(SLOT_CONTROL_OFF, 32'h0000_0400);
      repeat (20) @(negedge pclk);
      chk("reset_while_off", port_reset_out_n_o, 1'b0);
      wr(SLOT_CONTROL_OFF, 32'h0000_0000);
      repeat (400) @(negedge pclk);
      chk("delay_aborted", slot_power_enable_out, 1'b1);
      wr(HOTPLUG_CFG_OFF, 32'h0000_0100);
      wr(SLOT_CONTROL_OFF, 32'h0000_0400);
      wait_for(2, 1'b0, 4, n);
      final_report();
   end
endmodule : downstream_port_reset_sequencer_tb
